// ### src/pol_monitor_pkg.sv
package pol_monitor_pkg;
	// Command codes of the register bank.
	localparam logic [7:0] CODE_CORR_RATE = 8'hD2;
	localparam logic [7:0] CODE_SAMPLE_RATE = 8'hD3;
	localparam logic [7:0] CODE_VOUT_PEAK = 8'hD4;
	localparam logic [7:0] CODE_IOUT_PEAK = 8'hD5;
	localparam logic [7:0] CODE_TEMP_PEAK = 8'hD6;
	localparam logic [7:0] CODE_FILTER = 8'hD7;
	localparam logic [7:0] CODE_FAULT_STATUS = 8'hD8;
	localparam logic [7:0] CODE_RESPONSE = 8'hD9;
	// Reset values, the temperature-peak clear code, the lowest temperature and the response mask.
	localparam logic [15:0] CORR_RATE_RESET = 16'h000A;
	localparam logic [15:0] SAMPLE_RATE_RESET = 16'h0032;
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	localparam logic [15:0] TEMP_PEAK_CLEAR = 16'hFFFF;
	localparam logic [15:0] TEMP_LOWEST = 16'h8000;
	localparam logic [15:0] RESPONSE_MASK = 16'h83FF;
	// Fault status bit positions.
	localparam int ST_OTHER = 0;
	localparam int ST_CML = 1;
	localparam int ST_TEMP = 2;
	localparam int ST_OC_FAULT = 4;
	localparam int ST_OV_FAULT = 5;
	localparam int ST_OFF = 6;
	localparam int ST_OV_WARN = 8;
	localparam int ST_UV_FAULT = 9;
	localparam int ST_UV_WARN = 10;
	localparam int ST_NC_FAULT = 11;
	localparam int ST_OC_WARN = 12;
	localparam int ST_OVERTEMP_FAULT = 13;
	localparam int ST_OVERTEMP_WARNING = 14;
	localparam logic [15:0] STATUS_LIVE_MASK = 16'h7F73;
	localparam logic [7:0] HIGH_NON_TEMP_MASK = 8'h1F;
	// Response selector fields.
	localparam int RSP_OV_LSB = 0;
	localparam int RSP_UV_LSB = 2;
	localparam int RSP_OC_LSB = 4;
	localparam int RSP_OT_LSB = 6;
	localparam int RSP_NC_LSB = 8;
	localparam int RSP_STORE_PEAK = 15;
	// Filter field positions.
	localparam int FLT_COUNT_LSB = 0;
	localparam int FLT_DELAY_LSB = 8;
	// Timing.
	localparam int CLK_MHZ = 50;
	localparam int TICK_HZ = 10000;
	localparam int SPACE_BASE_NS = 1750;
	localparam int SPACE_STEP_NS = 250;
	localparam int NS_PER_US = 1000;

	typedef enum logic [1:0] {ACT_CONTINUE, ACT_SHUTDOWN, ACT_RETRY, ACT_STORE} action_t;

	typedef struct packed {
		logic write;
		logic [7:0] code;
		logic [15:0] wdata;
	} host_cmd_t;

	typedef struct packed {
		logic [15:0] ov_fault;
		logic [15:0] ov_warn;
		logic [15:0] uv_fault;
		logic [15:0] uv_warn;
		logic [15:0] oc_fault;
		logic [15:0] oc_warn;
		logic [15:0] overtemp_fault;
		logic [15:0] overtemp_warning;
	} limits_t;

	typedef struct packed {
		logic [15:0] vout;
		logic [15:0] iout;
		logic [15:0] temp;
	} peaks_t;
endpackage

// ### src/pol_monitor_fault_manager.sv
// Operation
// - In band, step DAC one LSB per rate
// - Correction rate zero stops in-band stepping
// - Correction rate resets to ten
// - Check faults every sample-rate ticks
// - Sample rate zero disables all checks
// - Sample rate resets to fifty
// - Voltage peak tracks largest, filtered when averaging
// - Zero clears peak; else sets threshold
// - All-ones resets temperature peak to lowest
// - Upper filter byte sets sample spacing
// - Lower byte sets two-power sample count
// - Averaged voltage compared against limits
// - Count zero disables filter; resets zero
// - Commands ignored while averaging runs
// - Detection sets status bit, asserts alert
// - Temperature summary bit; reserved bits zero
// - Other bit summarises non-temperature high bits
// - Reverse current sets bit eleven
// - Status read-only, cleared by fault clear
// - Two-bit selectors per fault, reset zero
// - Store-peak bit saves peaks on fault
// - Selectors 00/11 continue; saving needs bit 15
// - Selector 01 shuts down; 10 retries
// - Shutdown drops enable, ramps DAC down
// - After 01 shutdown, supply stays off until commanded on or a later 10-selected fault retries
// - Retry interval is register plus one 100us ticks
`timescale 1ns/100ps
module pol_monitor_fault_manager
	import pol_monitor_pkg::*;
#(
	parameter int TICK_CYCLES = CLK_MHZ * 1000000 / TICK_HZ,
	parameter int MAX_AVG_SHIFT = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic cmd_valid,
	input wire host_cmd_t cmd,
	output logic cmd_ready,
	output logic rsp_done,
	output logic rsp_ignored,
	output logic [15:0] rsp_data,
	input wire logic [15:0] vout_sample,
	input wire logic [15:0] iout_sample,
	input wire logic [15:0] temp_sample,
	input wire limits_t limits,
	input wire logic in_band,
	input wire logic [15:0] dac_target,
	input wire logic [15:0] restart_interval,
	input wire logic clear_faults,
	input wire logic cml_event,
	input wire logic supply_on_req,
	output logic [15:0] dac_output,
	output logic pol_enable_output,
	output logic fault_alert_pin_n,
	output logic peak_store_req,
	output peaks_t peak_store_data,
	output logic [15:0] fault_status_word
);
	initial
	begin
		if (TICK_CYCLES < 2 || MAX_AVG_SHIFT < 1 || MAX_AVG_SHIFT > 16)
			$error("Unsupported tick length or averaging depth.");
	end

	localparam int ACC_W = 16 + MAX_AVG_SHIFT;

	typedef enum {AVG_IDLE, AVG_RUN} avg_state_t;

	function automatic logic [15:0] space_cycles(input logic [7:0] delay);
		space_cycles = 16'(((SPACE_BASE_NS + SPACE_STEP_NS * int'(delay)) * CLK_MHZ
			+ NS_PER_US - 1) / NS_PER_US);
	endfunction

	function automatic action_t sel(input logic [15:0] rsp, input int lsb);
		sel = action_t'(rsp[lsb +: 2]);
	endfunction

	// Link side: capture a command and hand it across with a toggle.
	logic link_busy_reg, req_tgl_reg, ack_s1_reg, ack_s2_reg, ack_s3_reg;
	host_cmd_t cmd_hold_reg;
	logic ack_tgl_reg, res_ignored_reg;
	logic [15:0] res_data_reg;
	wire link_take = cmd_valid && !link_busy_reg;
	wire link_ack = ack_s2_reg ^ ack_s3_reg;

	always_ff @(posedge link_clk)
	begin
		if (link_rst)
		begin
			link_busy_reg <= 1'b0;
			req_tgl_reg <= 1'b0;
			cmd_hold_reg <= '0;
			{ack_s1_reg, ack_s2_reg, ack_s3_reg} <= 3'h0;
			cmd_ready <= 1'b0;
			rsp_done <= 1'b0;
			rsp_ignored <= 1'b0;
			rsp_data <= ZERO_WORD;
		end
		else
		begin
			{ack_s1_reg, ack_s2_reg, ack_s3_reg} <= {ack_tgl_reg, ack_s1_reg, ack_s2_reg};
			if (link_take)
			begin
				cmd_hold_reg <= cmd;
				req_tgl_reg <= ~req_tgl_reg;
			end
			link_busy_reg <= link_take || (link_busy_reg && !link_ack);
			cmd_ready <= !(link_take || (link_busy_reg && !link_ack));
			rsp_done <= link_ack;
			if (link_ack)
			begin
				rsp_ignored <= res_ignored_reg;
				rsp_data <= res_data_reg;
			end
		end
	end

	// Core side: synchronise the request toggle, then execute once.
	logic req_s1_reg, req_s2_reg, req_s3_reg;
	always_ff @(posedge clk)
	begin
		if (rst)
			{req_s1_reg, req_s2_reg, req_s3_reg} <= 3'h0;
		else
			{req_s1_reg, req_s2_reg, req_s3_reg} <= {req_tgl_reg, req_s1_reg, req_s2_reg};
	end
	wire cmd_exec = req_s2_reg ^ req_s3_reg;

	// Registers.
	logic [15:0] corr_rate_reg, sample_rate_reg, filter_reg, response_reg, status_reg;
	peaks_t peak_reg;
	avg_state_t avg_state_reg;
	wire avg_busy = (avg_state_reg == AVG_RUN);
	wire cmd_ignored = avg_busy;
	wire cmd_wr = cmd_exec && !cmd_ignored && cmd_hold_reg.write;
	wire [7:0] cmd_code = cmd_hold_reg.code;
	wire [15:0] cmd_wdata = cmd_hold_reg.wdata;
	wire wr_corr = cmd_wr && cmd_code == CODE_CORR_RATE;
	wire wr_rate = cmd_wr && cmd_code == CODE_SAMPLE_RATE;
	wire wr_vpk = cmd_wr && cmd_code == CODE_VOUT_PEAK;
	wire wr_ipk = cmd_wr && cmd_code == CODE_IOUT_PEAK;
	wire wr_tpk = cmd_wr && cmd_code == CODE_TEMP_PEAK;
	wire wr_filter = cmd_wr && cmd_code == CODE_FILTER;
	wire wr_response = cmd_wr && cmd_code == CODE_RESPONSE;
	wire code_known = cmd_code >= CODE_CORR_RATE && cmd_code <= CODE_RESPONSE;

	logic [15:0] read_mux;
	always_comb
	begin
		unique case (cmd_code)
			CODE_CORR_RATE: read_mux = corr_rate_reg;
			CODE_SAMPLE_RATE: read_mux = sample_rate_reg;
			CODE_VOUT_PEAK: read_mux = peak_reg.vout;
			CODE_IOUT_PEAK: read_mux = peak_reg.iout;
			CODE_TEMP_PEAK: read_mux = peak_reg.temp;
			CODE_FILTER: read_mux = filter_reg;
			CODE_FAULT_STATUS: read_mux = status_reg;
			CODE_RESPONSE: read_mux = response_reg;
			default: read_mux = ZERO_WORD;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ack_tgl_reg <= 1'b0;
			res_ignored_reg <= 1'b0;
			res_data_reg <= ZERO_WORD;
			corr_rate_reg <= CORR_RATE_RESET;
			sample_rate_reg <= SAMPLE_RATE_RESET;
			filter_reg <= ZERO_WORD;
			response_reg <= ZERO_WORD;
		end
		else
		begin
			if (cmd_exec)
			begin
				ack_tgl_reg <= ~ack_tgl_reg;
				res_ignored_reg <= cmd_ignored || !code_known;
				res_data_reg <= read_mux;
			end
			if (wr_corr)
				corr_rate_reg <= cmd_wdata;
			if (wr_rate)
				sample_rate_reg <= cmd_wdata;
			if (wr_filter)
				filter_reg <= cmd_wdata;
			if (wr_response)
				response_reg <= cmd_wdata & RESPONSE_MASK;
		end
	end

	// Shared 10 kHz tick and the two dividers it feeds.
	logic [31:0] tick_cnt_reg;
	logic [15:0] corr_cnt_reg, mon_cnt_reg;
	wire tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
	wire corr_step = tick && corr_rate_reg != ZERO_WORD
		&& corr_cnt_reg >= corr_rate_reg - 16'h0001;
	wire mon_tick = tick && sample_rate_reg != ZERO_WORD
		&& mon_cnt_reg >= sample_rate_reg - 16'h0001;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tick_cnt_reg <= '0;
			corr_cnt_reg <= ZERO_WORD;
			mon_cnt_reg <= ZERO_WORD;
		end
		else
		begin
			tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h1;
			if (tick)
				corr_cnt_reg <= corr_step ? ZERO_WORD : corr_cnt_reg + 16'h0001;
			if (tick)
				mon_cnt_reg <= mon_tick ? ZERO_WORD : mon_cnt_reg + 16'h0001;
		end
	end

	// Averaging sequencer.
	wire [7:0] count_byte = filter_reg[FLT_COUNT_LSB +: 8];
	wire [7:0] shift = (count_byte > 8'(MAX_AVG_SHIFT)) ? 8'(MAX_AVG_SHIFT) : count_byte;
	wire [16:0] n_samples = 17'h00001 << shift;
	logic [15:0] space_reg;
	logic [16:0] taken_reg;
	logic [ACC_W-1:0] acc_reg;
	wire space_done = (space_reg == ZERO_WORD);
	wire [ACC_W-1:0] acc_sum = acc_reg + ACC_W'(vout_sample);
	wire last_sample = avg_busy && space_done && taken_reg == n_samples - 17'h00001;
	wire eval = (mon_tick && !avg_busy && count_byte == 8'h00) || last_sample;
	wire [15:0] v_meas = avg_busy ? 16'(acc_sum >> shift) : vout_sample;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			avg_state_reg <= AVG_IDLE;
			space_reg <= ZERO_WORD;
			taken_reg <= '0;
			acc_reg <= '0;
		end
		else if (!avg_busy)
		begin
			if (mon_tick && count_byte != 8'h00)
				avg_state_reg <= AVG_RUN;
			space_reg <= ZERO_WORD;
			taken_reg <= '0;
			acc_reg <= '0;
		end
		else if (space_done)
		begin
			acc_reg <= acc_sum;
			taken_reg <= taken_reg + 17'h00001;
			space_reg <= space_cycles(filter_reg[FLT_DELAY_LSB +: 8]);
			if (last_sample)
				avg_state_reg <= AVG_IDLE;
		end
		else
			space_reg <= space_reg - 16'h0001;
	end

	// Fault and warning detection on each evaluation.
	wire signed [15:0] i_s = iout_sample;
	wire signed [15:0] t_s = temp_sample;
	logic [15:0] det;
	always_comb
	begin
		det = ZERO_WORD;
		det[ST_OV_FAULT] = v_meas >= limits.ov_fault;
		det[ST_OV_WARN] = v_meas >= limits.ov_warn;
		det[ST_UV_FAULT] = v_meas <= limits.uv_fault;
		det[ST_UV_WARN] = v_meas <= limits.uv_warn;
		det[ST_OC_FAULT] = i_s >= $signed(limits.oc_fault);
		det[ST_OC_WARN] = i_s >= $signed(limits.oc_warn);
		det[ST_NC_FAULT] = i_s < 16'sh0000;
		det[ST_OVERTEMP_FAULT] = t_s >= $signed(limits.overtemp_fault);
		det[ST_OVERTEMP_WARNING] = t_s >= $signed(limits.overtemp_warning);
	end
	wire [15:0] hit = eval ? det : ZERO_WORD;

	// Per-fault action decode.
	wire [4:0] fault_hit = {hit[ST_NC_FAULT], hit[ST_OVERTEMP_FAULT], hit[ST_OC_FAULT],
		hit[ST_UV_FAULT], hit[ST_OV_FAULT]};
	logic [4:0] want_shut, want_retry;
	generate
		for (genvar k = 0; k < 5; k++)
		begin : g_act
			assign want_shut[k] = fault_hit[k] && (sel(response_reg, 2 * k) == ACT_SHUTDOWN
				|| sel(response_reg, 2 * k) == ACT_RETRY);
			assign want_retry[k] = fault_hit[k] && sel(response_reg, 2 * k) == ACT_RETRY;
		end
	endgenerate
	wire shutdown = |want_shut;
	wire latch_off = |(want_shut & ~want_retry);
	wire store_evt = response_reg[RSP_STORE_PEAK] && |fault_hit;

	// Sticky status; a set in the clearing cycle wins.
	logic [15:0] raw_reg;
	wire [15:0] raw_next = (clear_faults ? ZERO_WORD : raw_reg) | hit
		| (shutdown ? 16'h0001 << ST_OFF : ZERO_WORD) | (cml_event ? 16'h0001 << ST_CML : ZERO_WORD);
	logic [15:0] status_next;
	always_comb
	begin
		status_next = raw_next & STATUS_LIVE_MASK;
		status_next[ST_TEMP] = raw_next[ST_OVERTEMP_WARNING] | raw_next[ST_OVERTEMP_FAULT];
		status_next[ST_OTHER] = |(raw_next[15:8] & HIGH_NON_TEMP_MASK);
	end

	// Supply enable, retry timer and DAC.
	logic retry_pend_reg;
	logic [15:0] retry_cnt_reg;
	wire retry_fire = retry_pend_reg && tick && retry_cnt_reg == ZERO_WORD;
	wire [15:0] dac_step = (dac_output < dac_target) ? dac_output + 16'h0001
		: (dac_output > dac_target) ? dac_output - 16'h0001 : dac_output;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			raw_reg <= ZERO_WORD;
			status_reg <= ZERO_WORD;
			pol_enable_output <= 1'b0;
			retry_pend_reg <= 1'b0;
			retry_cnt_reg <= ZERO_WORD;
			dac_output <= ZERO_WORD;
			fault_alert_pin_n <= 1'b1;
		end
		else
		begin
			raw_reg <= raw_next;
			status_reg <= status_next;
			fault_alert_pin_n <= !(|status_next);
			if (shutdown)
				pol_enable_output <= 1'b0;
			else if (supply_on_req || retry_fire)
				pol_enable_output <= 1'b1;
			if (shutdown || supply_on_req)
			begin
				retry_pend_reg <= !latch_off && !supply_on_req && shutdown;
				retry_cnt_reg <= restart_interval;
			end
			else if (retry_fire)
				retry_pend_reg <= 1'b0;
			else if (retry_pend_reg && tick)
				retry_cnt_reg <= retry_cnt_reg - 16'h0001;
			if (!pol_enable_output || shutdown)
			begin
				if (tick && dac_output != ZERO_WORD)
					dac_output <= dac_output - 16'h0001;
			end
			else if (in_band && corr_step)
				dac_output <= dac_step;
		end
	end

	// Peak trackers and the save request.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			peak_reg <= '0;
			peak_store_req <= 1'b0;
			peak_store_data <= '0;
		end
		else
		begin
			if (wr_vpk)
				peak_reg.vout <= cmd_wdata;
			else if (eval && v_meas > peak_reg.vout)
				peak_reg.vout <= v_meas;
			if (wr_ipk)
				peak_reg.iout <= cmd_wdata;
			else if (eval && i_s > $signed(peak_reg.iout))
				peak_reg.iout <= iout_sample;
			if (wr_tpk)
				peak_reg.temp <= (cmd_wdata == TEMP_PEAK_CLEAR) ? TEMP_LOWEST : cmd_wdata;
			else if (eval && t_s > $signed(peak_reg.temp))
				peak_reg.temp <= temp_sample;
			peak_store_req <= store_evt;
			if (store_evt)
				peak_store_data <= peak_reg;
		end
	end

	assign fault_status_word = status_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_reset_release;
		$fell(rst);
	endsequence

	a_reset_rate_values: assert property (s_reset_release |-> corr_rate_reg == CORR_RATE_RESET
		&& sample_rate_reg == SAMPLE_RATE_RESET) else $error("Rate registers not at reset values.");
	a_status_reserved_zero: assert property (status_reg[15] == 1'b0 && status_reg[7] == 1'b0
		&& status_reg[3] == 1'b0) else $error("Reserved status bit set.");
	a_temp_summary_bit: assert property (status_reg[ST_TEMP]
		== (status_reg[ST_OVERTEMP_WARNING] | status_reg[ST_OVERTEMP_FAULT])) else $error("Bad temp bit.");
	a_alert_follows_hit: assert property (|hit |=> !fault_alert_pin_n && |(status_reg & $past(hit)))
		else $error("Detection did not raise alert.");
	a_monitor_off_zero: assert property (sample_rate_reg == ZERO_WORD |-> !eval || avg_busy)
		else $error("Check ran with sample rate zero.");
	a_stepping_stops_zero: assert property (corr_rate_reg == ZERO_WORD && pol_enable_output
		&& !shutdown |=> $stable(dac_output)) else $error("DAC moved with rate zero.");
	a_shutdown_drops_enable: assert property (shutdown |=> !pol_enable_output [*2])
		else $error("Enable not dropped on shutdown.");
	a_busy_ignores_cmd: assert property (cmd_exec && avg_busy |=> res_ignored_reg
		&& $stable(filter_reg)) else $error("Command taken during averaging.");
	a_vpeak_zero_clear: assert property (wr_vpk && cmd_wdata == ZERO_WORD |=> peak_reg.vout
		== ZERO_WORD) else $error("Voltage peak not cleared.");
	a_tick_spacing: assert property (tick |=> !tick [*2]) else $error("Tick too close.");
endmodule

// ### verification/pmbus_host_model.sv
`timescale 1ns/100ps
module pmbus_host_model
	import pol_monitor_pkg::*;
(
	input wire logic link_clk,
	input wire logic cmd_ready,
	input wire logic rsp_done,
	input wire logic rsp_ignored,
	input wire logic [15:0] rsp_data,
	output logic cmd_valid,
	output host_cmd_t cmd
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd = '0;
	end

	// The command is held until the edge that takes it, then released.
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
		output logic [15:0] rd, output logic ign);
		int n;
		n = 0;
		@(negedge link_clk);
		cmd_valid = 1'b1;
		cmd = '{wr, code, wd};
		while (cmd_ready !== 1'b1 && n < 200)
		begin
			@(negedge link_clk);
			n++;
		end
		@(negedge link_clk);
		cmd_valid = 1'b0;
		// A released bus shows the inverse of its last value, never a stale copy.
		cmd = ~cmd;
		while (rsp_done !== 1'b1 && n < 400)
		begin
			@(negedge link_clk);
			n++;
		end
		rd = rsp_data;
		ign = rsp_ignored;
	endtask
endmodule

// ### verification/pol_monitor_fault_manager_tb.sv
`timescale 1ns/100ps
module pol_monitor_fault_manager_tb
	import pol_monitor_pkg::*;
;
	typedef struct packed {
		logic wr;
		logic [7:0] code;
		logic [15:0] wd;
		logic [15:0] exp;
		logic ign;
	} row_t;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic link_rst = 1'b1;
	logic in_band = 1'b0;
	logic clear_faults = 1'b0;
	logic supply_on_req = 1'b0;
	logic cmd_valid, cmd_ready, rsp_done, rsp_ignored, fault_alert_pin_n;
	logic pol_enable_output, peak_store_req, ign, hi, seen_store;
	host_cmd_t cmd;
	logic [15:0] rsp_data, dac_output, fault_status_word, rd, dv;
	logic [15:0] vout_sample = 16'h0000;
	logic [15:0] iout_sample = 16'h0000;
	logic [15:0] temp_sample = 16'h0000;
	logic [15:0] dac_target = 16'h0040;
	logic [15:0] restart_interval = 16'h0003;
	limits_t limits = '{16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h7FFF, 16'h7FFF,
		16'h7FFF, 16'h7FFF};
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;
	int n;
	row_t rows [17] = '{
		'{1'b0, 8'hD2, 16'h0000, 16'h000A, 1'b0}, '{1'b0, 8'hD3, 16'h0000, 16'h0032, 1'b0},
		'{1'b0, 8'hD4, 16'h0000, 16'h0000, 1'b0}, '{1'b0, 8'hD5, 16'h0000, 16'h0000, 1'b0},
		'{1'b0, 8'hD6, 16'h0000, 16'h0000, 1'b0}, '{1'b0, 8'hD7, 16'h0000, 16'h0000, 1'b0},
		'{1'b0, 8'hD8, 16'h0000, 16'h0000, 1'b0}, '{1'b0, 8'hD9, 16'h0000, 16'h0000, 1'b0},
		'{1'b0, 8'hDA, 16'h0000, 16'h0000, 1'b1}, '{1'b1, 8'hD9, 16'hFFFF, 16'h0000, 1'b0},
		'{1'b0, 8'hD9, 16'h0000, 16'h83FF, 1'b0}, '{1'b1, 8'hD8, 16'h1234, 16'h0000, 1'b0},
		'{1'b0, 8'hD8, 16'h0000, 16'h0000, 1'b0}, '{1'b1, 8'hD2, 16'h0002, 16'h000A, 1'b0},
		'{1'b0, 8'hD2, 16'h0000, 16'h0002, 1'b0}, '{1'b1, 8'hD9, 16'h0000, 16'h83FF, 1'b0},
		'{1'b1, 8'hD3, 16'h0000, 16'h0032, 1'b0}};

	pol_monitor_fault_manager #(.TICK_CYCLES(20)) uut (.clk, .rst, .link_clk, .link_rst,
		.cmd_valid, .cmd, .cmd_ready, .rsp_done, .rsp_ignored, .rsp_data, .vout_sample,
		.iout_sample, .temp_sample, .limits, .in_band, .dac_target, .restart_interval,
		.clear_faults, .cml_event(1'b0), .supply_on_req, .dac_output, .pol_enable_output,
		.fault_alert_pin_n, .peak_store_req, .peak_store_data(), .fault_status_word);

	pmbus_host_model host (.link_clk, .cmd_ready, .rsp_done, .rsp_ignored, .rsp_data,
		.cmd_valid, .cmd);

	always #10 clk = ~clk;

	initial
	begin
		#1.7;
		forever #3 link_clk = ~link_clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			close_out();
		end
	end

	always @(posedge clk)
		if (peak_store_req === 1'b1)
			seen_store = 1'b1;

	task automatic close_out();
		if (miscompares == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask

	task automatic rw(input logic wr, input logic [7:0] code, input logic [15:0] wd);
		host.xfer(wr, code, wd, rd, ign);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask

	task automatic wait_st();
		int k;
		k = 0;
		while (fault_status_word === 16'h0000 && k < 200)
		begin
			@(negedge clk);
			k++;
		end
		cyc(2);
	endtask

	// Counts cycles until the DAC code next moves, giving up after 500.
	task automatic gap(output int k);
		logic [15:0] d;
		d = dac_output;
		k = 0;
		while (dac_output === d && k < 500)
		begin
			@(negedge clk);
			k++;
		end
	endtask

	task automatic do_reset();
		rst = 1'b1;
		link_rst = 1'b1;
		cyc(5);
		rst = 1'b0;
		link_rst = 1'b0;
		cyc(2);
	endtask

	task automatic run_rows(input int last);
		for (int i = 0; i <= last; i++)
		begin
			rw(rows[i].wr, rows[i].code, rows[i].wd);
			chk("refusal", {15'h0000, rows[i].ign}, {15'h0000, ign});
			if (!rows[i].ign)
				chk("read data", rows[i].exp, rd);
		end
	endtask

	initial
	begin
		do_reset();
		run_rows(16);
		vout_sample = 16'h9000;
		limits.ov_warn = 16'h8000;
		cyc(400);
		chk("status", 16'h0000, fault_status_word);
		rw(1'b1, 8'hD3, 16'h0002);
		wait_st();
		chk("status", 16'h0101, fault_status_word);
		chk("alert", 16'h0000, {15'h0000, fault_alert_pin_n});
		rw(1'b0, 8'hD4, 16'h0000);
		chk("vout peak", 16'h9000, rd);
		rw(1'b1, 8'hD4, 16'hA000);
		vout_sample = 16'h9800;
		cyc(200);
		rw(1'b0, 8'hD4, 16'h0000);
		chk("vout peak", 16'hA000, rd);
		// A zero voltage would meet the undervoltage limits, so stay mid-range.
		vout_sample = 16'h4000;
		rw(1'b1, 8'hD3, 16'h0000);
		rw(1'b1, 8'hD4, 16'h0000);
		cyc(100);
		rw(1'b0, 8'hD4, 16'h0000);
		chk("vout peak", 16'h0000, rd);
		rw(1'b1, 8'hD3, 16'h0002);
		pulse(clear_faults);
		cyc(2);
		chk("status", 16'h0000, fault_status_word);
		chk("alert", 16'h0001, {15'h0000, fault_alert_pin_n});
		temp_sample = 16'h0100;
		limits.overtemp_warning = 16'h0080;
		wait_st();
		chk("status", 16'h4004, fault_status_word);
		rw(1'b0, 8'hD6, 16'h0000);
		chk("temp peak", 16'h0100, rd);
		temp_sample = 16'h8000;
		rw(1'b1, 8'hD6, 16'hFFFF);
		rw(1'b0, 8'hD6, 16'h0000);
		chk("temp peak", 16'h8000, rd);
		iout_sample = 16'hFFF0;
		pulse(clear_faults);
		wait_st();
		chk("status", 16'h0801, fault_status_word);
		iout_sample = 16'h0000;
		pulse(clear_faults);
		pulse(supply_on_req);
		in_band = 1'b1;
		gap(n);
		dv = dac_output;
		gap(n);
		chk("step gap", 16'h0028, n[15:0]);
		chk("step", dv + 16'h0001, dac_output);
		cyc(400);
		rw(1'b1, 8'hD2, 16'h0000);
		gap(n);
		chk("step gap", 16'h01F4, n[15:0]);
		limits.ov_fault = 16'h9800;
		for (int s = 0; s < 4; s++)
		begin
			rw(1'b1, 8'hD9, {s != 0, 13'h0000, s[1:0]});
			pulse(supply_on_req);
			pulse(clear_faults);
			seen_store = 1'b0;
			vout_sample = 16'hA000;
			wait_st();
			chk("enable", {15'h0000, s == 0 || s == 3}, {15'h0000, pol_enable_output});
			chk("store", {15'h0000, s != 0}, {15'h0000, seen_store});
			chk("ov bit", 16'h0001, {15'h0000, fault_status_word[5]});
			if (s == 1)
			begin
				gap(n);
				dv = dac_output;
				gap(n);
				chk("ramp gap", 16'h0014, n[15:0]);
				chk("ramp", dv - 16'h0001, dac_output);
			end
			// The fault must go away, or each new detection restarts the retry wait.
			vout_sample = 16'h4000;
			hi = 1'b0;
			repeat (300)
			begin
				@(negedge clk);
				hi = hi | pol_enable_output;
			end
			chk("restart", {15'h0000, s != 1}, {15'h0000, hi});
		end
		rw(1'b1, 8'hD7, 16'hFF01);
		hi = 1'b0;
		repeat (40)
		begin
			rw(1'b0, 8'hD2, 16'h0000);
			hi = hi | ign;
		end
		chk("busy refusal", 16'h0001, {15'h0000, hi});
		do_reset();
		run_rows(8);
		close_out();
	end
endmodule
